// ==== hdl/trip_regs.svh ====
/*
  Constants of the trippoint unit: limits, timing figures, stop code, input counts.
  Assumes a 10 MHz sequencer clock; included by trip_pkg and the unit itself.
*/
`ifndef TRIP_REGS_SVH
`define TRIP_REGS_SVH
`define MAX_AXES 8
`define MAX_THREADS 8
`define CLK_FREQ_KHZ 10000
`define MS_TIME_US 1000
`define SAMPLE_TIME_US 1000
`define MS_CYCLES ((`MS_TIME_US * `CLK_FREQ_KHZ) / 1000)
`define SAMPLE_CYCLES ((`SAMPLE_TIME_US * `CLK_FREQ_KHZ) / 1000)
`define STOP_CODE_SETTLE 8'h63
`define INPUTS_SMALL 8
`define INPUTS_MID 24
`define INPUTS_LARGE 80
`endif

// ==== hdl/trip_pkg.sv ====
/*
  Types of the trippoint unit: wait opcodes, command word, thread states.
  Assumes trip_regs.svh is on the include path.
*/
`include "trip_regs.svh"
package trip_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_MOTION = 4'h1,
    OP_REL = 4'h2,
    OP_INC = 4'h3,
    OP_ABS = 4'h4,
    OP_FWD = 4'h5,
    OP_REV = 4'h6,
    OP_INPOS = 4'h7,
    OP_INPUT = 4'h8,
    OP_SLEW = 4'h9,
    OP_TIME = 4'hA,
    OP_PATH = 4'hB,
    OP_DELAY = 4'hC,
    OP_REL_MOVE = 4'hD
  } op_t;

  // axis_mask bit MAX_AXES stands for the coordinated sequence
  typedef struct packed {
    op_t op;
    logic [2:0] thread;
    logic [`MAX_AXES:0] axis_mask;
    logic aux_src;
    logic signed [31:0] arg;
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SETTLE = 2'b11
  } state_t;
endpackage

// ==== hdl/motion_event_trippoints.sv ====
/*
  Trippoint unit: holds each sequencer thread until its chosen event trips.
  Assumes commands arrive as one-cycle strobes from the sequencer, and that the
  profilers, encoders and inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trip_regs.svh"
module motion_event_trippoints
  import trip_pkg::*;
#(
  parameter int NUM_AXES = `MAX_AXES,
  parameter int NUM_THREADS = `MAX_THREADS,
  parameter int NUM_INPUTS = `INPUTS_LARGE,
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // sequencer command
  input wire cmd_t cmd_i,
  input wire logic cmd_valid_i,
  // axis profilers and encoders
  input wire logic [NUM_AXES-1:0][31:0] cmd_pos_i,
  input wire logic [NUM_AXES-1:0][31:0] enc_pos_i,
  input wire logic [NUM_AXES-1:0][31:0] aux_pos_i,
  input wire logic [NUM_AXES-1:0][31:0] move_start_pos_i,
  input wire logic [NUM_AXES-1:0] motion_done_i,
  input wire logic seq_done_i,
  input wire logic [NUM_AXES-1:0] at_slew_i,
  input wire logic [NUM_AXES-1:0] profile_done_i,
  input wire logic [NUM_AXES-1:0][15:0] settle_timeout_value_i,
  input wire logic [31:0] path_dist_i,
  input wire logic path_start_i,
  // digital inputs
  input wire logic [NUM_INPUTS-1:0] din_i,
  // per-thread sequencer control
  output logic [NUM_THREADS-1:0] halt_o,
  output logic [NUM_THREADS-1:0] resume_o,
  output logic [NUM_THREADS-1:0] cmd_err_o,
  output logic [NUM_THREADS-1:0] settle_timeout_handler_o,
  // stop code write
  output logic stop_wr_o,
  output logic [$clog2(NUM_AXES)-1:0] stop_axis_o,
  output logic [7:0] stop_code_o,
  // relative move gate
  output logic move_ok_o,
  output logic move_reject_o
);
  localparam int AXW = $clog2(NUM_AXES);
  localparam int TW = $clog2(NUM_THREADS);

  initial begin
    if (NUM_AXES < 2 || NUM_AXES > `MAX_AXES) $error("NUM_AXES out of range");
    if (NUM_THREADS < 2 || NUM_THREADS > `MAX_THREADS) $error("NUM_THREADS out of range");
    if (NUM_INPUTS != `INPUTS_SMALL && NUM_INPUTS != `INPUTS_MID && NUM_INPUTS != `INPUTS_LARGE) begin
      $error("NUM_INPUTS must be 8, 24 or 80");
    end
    if (MS_CYCLES < 1 || SAMPLE_CYCLES < 1) $error("tick counts must be at least 1");
  end

  function automatic logic [AXW-1:0] axis_index(input logic [NUM_AXES-1:0] m);
    logic [AXW-1:0] idx;
    idx = '0;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (m[i]) idx = AXW'(i);
    end
    return idx;
  endfunction

  function automatic logic [32:0] mag_diff(input logic signed [31:0] a, input logic signed [31:0] b);
    logic signed [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  // millisecond and servo-sample enables
  logic [31:0] ms_div_r;
  logic [31:0] smp_div_r;
  logic ms_tick_r;
  logic sample_tick_r;
  logic [31:0] ms_cnt_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_div_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
      ms_cnt_r <= 32'h0000_0000;
    end else begin
      ms_tick_r <= (ms_div_r == 32'(MS_CYCLES - 1));
      ms_div_r <= (ms_div_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_div_r + 32'h0000_0001;
      if (ms_tick_r) ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      smp_div_r <= 32'h0000_0000;
      sample_tick_r <= 1'b0;
    end else begin
      sample_tick_r <= (smp_div_r == 32'(SAMPLE_CYCLES - 1));
      smp_div_r <= (smp_div_r == 32'(SAMPLE_CYCLES - 1)) ? 32'h0000_0000 : smp_div_r + 32'h0000_0001;
    end
  end

  // decode shared by all threads
  logic [NUM_AXES-1:0] iss_axes;
  logic [AXW-1:0] iss_ax;
  logic iss_one;
  logic [32:0] iss_mag;
  logic iss_bad;

  always_comb begin
    iss_axes = cmd_i.axis_mask[NUM_AXES-1:0];
    iss_ax = axis_index(iss_axes);
    iss_one = $onehot(iss_axes) && !cmd_i.axis_mask[`MAX_AXES];
    iss_mag = mag_diff(cmd_i.arg, 32'sh0000_0000);
    case (cmd_i.op)
      OP_REL, OP_INC, OP_ABS, OP_FWD, OP_REV, OP_INPOS: iss_bad = !iss_one;
      OP_INPUT: iss_bad = (iss_mag == 33'h0_0000_0000) || (iss_mag > 33'(NUM_INPUTS));
      OP_DELAY, OP_PATH: iss_bad = cmd_i.arg[31];
      OP_MOTION, OP_SLEW, OP_TIME: iss_bad = 1'b0;
      default: iss_bad = 1'b1;
    endcase
  end

  // relative move gate
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      move_ok_o <= 1'b0;
      move_reject_o <= 1'b0;
    end else begin
      move_ok_o <= cmd_valid_i && cmd_i.op == OP_REL_MOVE && iss_one && motion_done_i[iss_ax];
      move_reject_o <= cmd_valid_i && cmd_i.op == OP_REL_MOVE && !(iss_one && motion_done_i[iss_ax]);
    end
  end

  logic [NUM_THREADS-1:0] tmo_w;
  logic [NUM_THREADS-1:0][AXW-1:0] tax_w;

  for (genvar t = 0; t < NUM_THREADS; t++) begin : g_thread
    state_t state_r;
    op_t op_r;
    logic [NUM_AXES:0] mask_r;
    logic [AXW-1:0] ax_r;
    logic aux_r;
    logic up_r;
    logic signed [31:0] arg_r;
    logic [32:0] mag_r;
    logic signed [31:0] ref_pos_r;
    logic [31:0] time_ref_r;
    logic [31:0] delay_ref_r;
    logic [31:0] path_ref_r;
    logic [15:0] settle_cnt_r;
    logic halt_r;
    logic resume_r;
    logic err_r;
    logic tmo_r;
    logic issue;
    logic trip;
    logic reached;
    logic settle_over;
    logic signed [31:0] p_cmd;
    logic signed [31:0] p_enc;
    logic signed [31:0] p_src;
    logic [31:0] elapsed;

    assign issue = cmd_valid_i && cmd_i.thread == 3'(t) && cmd_i.op != OP_REL_MOVE && state_r == ST_IDLE;

    always_comb begin
      p_cmd = $signed(cmd_pos_i[ax_r]);
      p_enc = $signed(enc_pos_i[ax_r]);
      p_src = aux_r ? $signed(aux_pos_i[ax_r]) : p_enc;
      elapsed = ms_cnt_r - time_ref_r;
      reached = up_r ? (p_enc >= arg_r) : (p_enc <= arg_r);
      settle_over = settle_timeout_value_i[ax_r] != 16'h0000 && settle_cnt_r >= settle_timeout_value_i[ax_r];
      case (op_r)
        OP_MOTION: trip = &({seq_done_i, motion_done_i} | ~mask_r);
        OP_REL: trip = mag_diff(p_cmd, $signed(move_start_pos_i[ax_r])) >= mag_r;
        OP_INC: trip = mag_diff(p_cmd, ref_pos_r) >= mag_r;
        OP_ABS: trip = up_r ? (p_cmd >= arg_r) : (p_cmd <= arg_r);
        OP_FWD: trip = p_src >= arg_r;
        OP_REV: trip = p_src <= arg_r;
        OP_INPOS: trip = profile_done_i[ax_r] && reached;
        OP_INPUT: trip = din_i[mag_r[6:0] - 7'h01] == !arg_r[31];
        OP_SLEW: trip = &(at_slew_i | ~mask_r[NUM_AXES-1:0]);
        OP_TIME: trip = {1'b0, elapsed} >= mag_r;
        OP_PATH: trip = (path_dist_i - path_ref_r) >= arg_r[31:0];
        OP_DELAY: trip = (ms_cnt_r - delay_ref_r) >= arg_r[31:0];
        default: trip = 1'b0;
      endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        state_r <= ST_IDLE;
        op_r <= OP_NONE;
        mask_r <= '0;
        ax_r <= '0;
        aux_r <= 1'b0;
        up_r <= 1'b0;
        arg_r <= 32'sh0000_0000;
        mag_r <= 33'h0_0000_0000;
        settle_cnt_r <= 16'h0000;
        halt_r <= 1'b0;
        resume_r <= 1'b0;
        err_r <= 1'b0;
        tmo_r <= 1'b0;
      end else begin
        resume_r <= 1'b0;
        err_r <= 1'b0;
        tmo_r <= 1'b0;
        case (state_r)
          ST_IDLE: begin
            if (issue) begin
              op_r <= cmd_i.op;
              mask_r <= (cmd_i.axis_mask == '0) ? '1 : {cmd_i.axis_mask[`MAX_AXES], iss_axes};
              ax_r <= iss_ax;
              aux_r <= cmd_i.aux_src;
              arg_r <= cmd_i.arg;
              mag_r <= iss_mag;
              up_r <= (cmd_i.op == OP_ABS ? $signed(cmd_pos_i[iss_ax]) : $signed(enc_pos_i[iss_ax])) < cmd_i.arg;
              settle_cnt_r <= 16'h0000;
              if (iss_bad) begin
                err_r <= 1'b1;
              end else if (cmd_i.op == OP_TIME && iss_mag == 33'h0_0000_0000) begin
                resume_r <= 1'b1;
              end else begin
                state_r <= ST_WAIT;
                halt_r <= 1'b1;
              end
            end
          end
          ST_WAIT: begin
            if (op_r == OP_INPOS && sample_tick_r && profile_done_i[ax_r] && !reached) begin
              state_r <= ST_SETTLE;
            end else if (trip && (sample_tick_r || op_r == OP_TIME || op_r == OP_DELAY || op_r == OP_INPUT)) begin
              state_r <= ST_IDLE;
              halt_r <= 1'b0;
              resume_r <= 1'b1;
            end
          end
          ST_SETTLE: begin
            if (ms_tick_r && settle_cnt_r != 16'hFFFF) settle_cnt_r <= settle_cnt_r + 16'h0001;
            if (sample_tick_r && reached) begin
              state_r <= ST_IDLE;
              halt_r <= 1'b0;
              resume_r <= 1'b1;
            end else if (settle_over) begin
              state_r <= ST_IDLE;
              halt_r <= 1'b0;
              err_r <= 1'b1;
              tmo_r <= 1'b1;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            halt_r <= 1'b0;
          end
        endcase
      end
    end

    // references survive between waits of this thread only
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        ref_pos_r <= 32'sh0000_0000;
        time_ref_r <= 32'h0000_0000;
        delay_ref_r <= 32'h0000_0000;
        path_ref_r <= 32'h0000_0000;
      end else begin
        if (issue && cmd_i.op == OP_TIME && iss_mag == 33'h0_0000_0000) time_ref_r <= ms_cnt_r;
        if (issue && cmd_i.op == OP_DELAY) delay_ref_r <= ms_cnt_r;
        if (state_r == ST_WAIT && trip && sample_tick_r && (op_r == OP_INC || op_r == OP_REL)) begin
          ref_pos_r <= p_cmd;
        end
        if (state_r == ST_WAIT && trip && op_r == OP_TIME && arg_r[31]) begin
          time_ref_r <= time_ref_r + mag_r[31:0];
        end
        if (path_start_i) begin
          path_ref_r <= 32'h0000_0000;
        end else if (state_r == ST_WAIT && trip && sample_tick_r && op_r == OP_PATH) begin
          path_ref_r <= path_dist_i;
        end
      end
    end

    assign halt_o[t] = halt_r;
    assign resume_o[t] = resume_r;
    assign cmd_err_o[t] = err_r;
    assign settle_timeout_handler_o[t] = tmo_r;
    assign tmo_w[t] = tmo_r;
    assign tax_w[t] = ax_r;
  end

  // lowest thread wins when two settle timeouts land together; the other code is lost
  logic [AXW-1:0] tmo_ax;
  always_comb begin
    tmo_ax = '0;
    for (int t = NUM_THREADS - 1; t >= 0; t--) begin
      if (tmo_w[t]) tmo_ax = tax_w[t];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_wr_o <= 1'b0;
      stop_axis_o <= '0;
      stop_code_o <= 8'h00;
    end else begin
      stop_wr_o <= |tmo_w;
      if (|tmo_w) begin
        stop_axis_o <= tmo_ax;
        stop_code_o <= `STOP_CODE_SETTLE;
      end
    end
  end

  logic unused_tw;
  assign unused_tw = TW > 0;
endmodule
`default_nettype wire

// ==== testbench/trip_sva.sv ====
/*
  Checker for the trippoint unit, bound to its top ports.
  Assumes one clock domain and thread 0 as the watched thread.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trip_regs.svh"
module trip_sva
  import trip_pkg::*;
#(
  parameter int NUM_AXES = 8,
  parameter int NUM_THREADS = 8,
  parameter int NUM_INPUTS = 80
) (
  // watched ports
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire cmd_t cmd_i,
  input wire logic cmd_valid_i,
  input wire logic [NUM_AXES-1:0] motion_done_i,
  input wire logic [NUM_INPUTS-1:0] din_i,
  input wire logic [NUM_THREADS-1:0] halt_o,
  input wire logic [NUM_THREADS-1:0] resume_o,
  input wire logic [NUM_THREADS-1:0] cmd_err_o,
  input wire logic [NUM_THREADS-1:0] settle_timeout_handler_o,
  input wire logic stop_wr_o,
  input wire logic [7:0] stop_code_o,
  input wire logic move_ok_o,
  input wire logic move_reject_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic take0;
  assign take0 = cmd_valid_i && !halt_o[0] && cmd_i.thread == 3'h0;
  property p_trip;
    $fell(halt_o[0]) |-> resume_o[0] || settle_timeout_handler_o[0];
  endproperty
  property p_delay;
    take0 && cmd_i.op == OP_DELAY && cmd_i.arg == 2 |=> halt_o[0] [*4] ##[1:9] resume_o[0];
  endproperty
  property p_code;
    stop_wr_o |-> stop_code_o == `STOP_CODE_SETTLE;
  endproperty
  property p_stop;
    |settle_timeout_handler_o |=> stop_wr_o;
  endproperty
  property p_handler;
    settle_timeout_handler_o[0] |-> cmd_err_o[0];
  endproperty
  property p_single;
    take0 && cmd_i.op inside {OP_REL, OP_INC, OP_ABS, OP_FWD, OP_REV, OP_INPOS}
      && $countones(cmd_i.axis_mask) != 1 |=> cmd_err_o[0] && !halt_o[0];
  endproperty
  property p_move;
    take0 && cmd_i.op == OP_REL_MOVE && cmd_i.axis_mask == 9'h001
      |=> move_reject_o == !$past(motion_done_i[0]) && move_ok_o == $past(motion_done_i[0]);
  endproperty
  property p_input;
    take0 && cmd_i.op == OP_INPUT && cmd_i.arg == 1 && din_i[0] |=> ##[0:2] resume_o[0];
  endproperty
  property p_ref;
    take0 && cmd_i.op == OP_TIME && cmd_i.arg == 0 |=> resume_o[0] && !halt_o[0];
  endproperty
  a_trip: assert property (p_trip) else $error("halt dropped without resume");
  a_delay: assert property (p_delay) else $error("delay wait length wrong");
  a_code: assert property (p_code) else $error("stop code not 99");
  a_stop: assert property (p_stop) else $error("no stop code write after timeout");
  a_handler: assert property (p_handler) else $error("handler branch without error");
  a_single: assert property (p_single) else $error("multi axis wait accepted");
  a_move: assert property (p_move) else $error("relative move answer wrong");
  a_input: assert property (p_input) else $error("input wait did not trip");
  a_ref: assert property (p_ref) else $error("reference set did not resume");
  c_stop: cover property (stop_wr_o);
  c_reject: cover property (move_reject_o);
  c_trip: cover property ($fell(halt_o[0]));
endmodule
bind motion_event_trippoints trip_sva #(.NUM_AXES(NUM_AXES), .NUM_THREADS(NUM_THREADS), .NUM_INPUTS(NUM_INPUTS)) u_sva (
  .clk_i, .resetn_i, .cmd_i, .cmd_valid_i, .motion_done_i, .din_i, .halt_o, .resume_o,
  .cmd_err_o, .settle_timeout_handler_o, .stop_wr_o, .stop_code_o, .move_ok_o, .move_reject_o);
`default_nettype wire

// ==== testbench/axis_model.sv ====
/*
  Profiler model: axis 0 ramps up to a target at a fixed step, others idle.
  Assumes targets only above the current position.
*/
`timescale 1ns/1ps
`default_nettype none
module axis_model #(
  parameter int STEP = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // move request
  input wire logic go_i,
  input wire logic [31:0] target_i,
  // axis state
  output logic [7:0][31:0] pos_o,
  output logic [7:0] done_o
);
  logic moving_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_o <= '0;
      moving_r <= 1'b0;
    end else if (go_i) begin
      moving_r <= 1'b1;
    end else if (moving_r) begin
      // clamp so the last step lands exactly on target
      if (pos_o[0] + STEP >= target_i) begin
        pos_o[0] <= target_i;
        moving_r <= 1'b0;
      end else begin
        pos_o[0] <= pos_o[0] + STEP;
      end
    end
  end
  assign done_o = {7'h7F, !moving_r};
endmodule
`default_nettype wire

// ==== testbench/motion_event_trippoints_test.sv ====
/*
  Testbench of the trippoint unit, thread 0 and 1, one profiler model.
  Assumes short ms and sample dividers set here.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_event_trippoints_test;
  import trip_pkg::*;
  localparam int MS = 4;
  localparam int SMP = 3;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  cmd_t cmd_i;
  logic cmd_valid_i, go, aux_sel, stop_wr_o, move_ok_o, move_reject_o;
  logic [31:0] target, start;
  logic [7:0][31:0] pos;
  logic [7:0] done, halt_o, resume_o, cmd_err_o, settle_timeout_handler_o, stop_code_o;
  logic [79:0] din_i;
  logic [2:0] stop_axis_o;
  int fails = 0;
  int samples_checked = 0;
  int n;
  always #50 clk_i = ~clk_i;
  axis_model partner (.clk_i, .resetn_i, .go_i(go), .target_i(target), .pos_o(pos), .done_o(done));
  motion_event_trippoints #(.MS_CYCLES(MS), .SAMPLE_CYCLES(SMP)) dut (
    .clk_i, .resetn_i, .cmd_i, .cmd_valid_i, .cmd_pos_i(pos), .enc_pos_i(pos), .aux_pos_i({8{32'h0000_03E8}}),
    .move_start_pos_i({224'h0, start}), .motion_done_i(done), .seq_done_i(1'b1), .at_slew_i(~done),
    .profile_done_i(done), .settle_timeout_value_i({112'h0, 16'h0001}), .path_dist_i(pos[0] - start),
    .path_start_i(1'b0), .din_i, .halt_o, .resume_o, .cmd_err_o, .settle_timeout_handler_o,
    .stop_wr_o, .stop_axis_o, .stop_code_o, .move_ok_o, .move_reject_o);
  task automatic print_verdict();
    $display("Checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic issue(input op_t op, input logic [2:0] thr, input logic [8:0] mask, input int arg);
    @(posedge clk_i);
    cmd_i <= '{op: op, thread: thr, axis_mask: mask, aux_src: aux_sel, arg: arg};
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask
  // sel 0 waits for resume, 1 for error; n counts edges from the take edge, which is edge 1,
  // because a pulse registered at the take edge is already gone by the next one
  task automatic wait_for(input int sel, input int thr, input int max, output int cnt);
    for (cnt = 1; cnt <= max; cnt++) begin
      if (cnt > 1) begin
        @(posedge clk_i);
        #1;
      end
      if ((sel == 0 ? resume_o[thr] : cmd_err_o[thr]) === 1'b1) return;
    end
    fails++;
    $display("Error at %0t: wait timed out", $time);
    print_verdict();
  endtask
  task automatic move(input logic [31:0] t);
    @(posedge clk_i);
    target <= t;
    start <= pos[0];
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic t_time();
    issue(OP_TIME, 3'h0, 9'h0, 0);
    wait_for(0, 0, 2, n);
    chk(n, 1);
    issue(OP_TIME, 3'h0, 9'h0, -2);
    chk(halt_o[0], 1'b1);
    wait_for(0, 0, 20, n);
    issue(OP_TIME, 3'h0, 9'h0, 2);
    wait_for(0, 0, 20, n);
    chk(n >= MS, 1);
  endtask
  task automatic t_delay();
    issue(OP_DELAY, 3'h1, 9'h0, 5);
    issue(OP_DELAY, 3'h0, 9'h0, 2);
    chk(halt_o[0], 1'b1);
    wait_for(0, 0, 20, n);
    chk(n >= MS && n <= 3 * MS, 1);
    chk(halt_o, 8'h02);
    wait_for(0, 1, 30, n);
  endtask
  task automatic t_input();
    din_i <= '0;
    issue(OP_INPUT, 3'h0, 9'h0, 1);
    repeat (3) @(posedge clk_i);
    din_i[0] <= 1'b1;
    #1;
    chk(halt_o[0], 1'b1);
    wait_for(0, 0, 4, n);
    issue(OP_INPUT, 3'h0, 9'h0, -80);
    wait_for(0, 0, 3, n);
    issue(OP_INPUT, 3'h0, 9'h0, 1);
    wait_for(0, 0, 3, n);
    chk(n, 2);
    for (int k = 0; k < 3; k++) begin
      issue(OP_INPUT, 3'h0, 9'h0, k == 0 ? 81 : (k == 1 ? 0 : -81));
      wait_for(1, 0, 2, n);
      chk(n, 1);
    end
  endtask
  task automatic t_single();
    for (int op = OP_REL; op <= OP_INPOS; op++) begin
      issue(op_t'(op), 3'h0, op[0] ? 9'h003 : 9'h000, 100);
      wait_for(1, 0, 2, n);
      chk(n, 1);
    end
  endtask
  task automatic t_motion();
    move(400);
    issue(OP_REL_MOVE, 3'h0, 9'h001, 100);
    chk({move_ok_o, move_reject_o}, 2'b01);
    issue(OP_MOTION, 3'h0, 9'h001, 0);
    wait_for(0, 0, 80, n);
    chk(pos[0], 400);
    issue(OP_REL_MOVE, 3'h0, 9'h001, 100);
    chk({move_ok_o, move_reject_o}, 2'b10);
  endtask
  // the auxiliary source stands at 1000 while the encoder stops at 800, so only it can trip the forward wait at 900
  task automatic t_abs();
    move(800);
    issue(OP_ABS, 3'h0, 9'h001, 600);
    wait_for(0, 0, 60, n);
    chk(pos[0] >= 600 && pos[0] <= 600 + 8 * (SMP + 2), 1);
    aux_sel = 1'b1;
    issue(OP_FWD, 3'h0, 9'h001, 900);
    wait_for(0, 0, SMP + 2, n);
    aux_sel = 1'b0;
    issue(OP_REV, 3'h0, 9'h001, 900);
    wait_for(0, 0, SMP + 2, n);
    issue(OP_MOTION, 3'h0, 9'h000, 0);
    wait_for(0, 0, 60, n);
  endtask
  // one move from 800 to 1400 serves the slew, relative, increment and path waits in turn
  task automatic t_rel();
    move(1400);
    issue(OP_SLEW, 3'h0, 9'h001, 0);
    wait_for(0, 0, SMP + 2, n);
    issue(OP_REL, 3'h0, 9'h001, 100);
    wait_for(0, 0, 40, n);
    chk(pos[0] >= 900 && pos[0] <= 900 + 8 * (SMP + 2), 1);
    issue(OP_INC, 3'h0, 9'h001, 100);
    wait_for(0, 0, 40, n);
    chk(pos[0] >= 1000 && pos[0] <= 1000 + 8 * (2 * SMP + 2), 1);
    issue(OP_PATH, 3'h0, 9'h000, 300);
    wait_for(0, 0, 40, n);
    chk(pos[0] >= 1100 && pos[0] <= 1100 + 8 * (SMP + 2), 1);
    issue(OP_PATH, 3'h0, 9'h000, 50);
    wait_for(0, 0, 40, n);
    chk(pos[0] >= 1150 && pos[0] <= 1150 + 8 * (2 * SMP + 2), 1);
    issue(OP_MOTION, 3'h0, 9'h000, 0);
    wait_for(0, 0, 80, n);
  endtask
  task automatic t_settle();
    issue(OP_INPOS, 3'h0, 9'h001, 5000);
    wait_for(1, 0, 30, n);
    chk(settle_timeout_handler_o[0], 1'b1);
    @(posedge clk_i);
    #1;
    chk({stop_wr_o, stop_axis_o, stop_code_o}, {1'b1, 3'h0, 8'h63});
    chk(halt_o[0], 1'b0);
  endtask
  initial begin
    cmd_i = '0;
    cmd_valid_i = 1'b0;
    din_i = '0;
    go = 1'b0;
    target = '0;
    start = '0;
    aux_sel = 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_time();
    t_delay();
    t_input();
    t_single();
    t_motion();
    t_abs();
    t_rel();
    t_settle();
    print_verdict();
  end
endmodule
`default_nettype wire
